// >>> rtl/sstsq_top.sv
`timescale 1ns/100ps
// How it works
// - Actuator present, both safety inputs low: green blinks, diagnosis high, outputs off.
// - Inputs high but start pulse awaited: green flashes, diagnosis high, outputs off.
// - Actuator at range edge: yellow blinks, diagnosis pulsed, outputs keep previous state.
// - Learning pending: yellow flashes, diagnosis pulsed, outputs off until power removed.
// - Error: red shows pulse code, other lamps dark, diagnosis and outputs low.
// - Blink pattern has equal on and off time.
// - Flash pattern has on to off ratio one to five.
// - First power-up with nothing learned accepts the first permissible actuator at once.
// - New permissible actuator in teach operation is acknowledged by six red blinks.
// - After recognition wait ten seconds with actuator present, then start learning.
// - Learning completes only if power drops within two minutes of learning start.
// - Next power-up after a valid learning cycle commits the new actuator code.
// - Committing a new actuator blocks the previously accepted code in one of four entries, which the fourth later commit reuses.
// - Teaching repeats without limit but never learns a blocked code.
// - Actuator leaving during learning cancels teaching until the next power cycle.
// - Safety-input faults report as a two-pulse red code.
// - Feedback-input faults report as a three-pulse red code.
// - Supply over- or under-voltage reports as a four-pulse red code.
// - Any error stays latched until supply power is cycled.
// - Everything correct: green steady, diagnosis and both safety outputs high.
// - Temperature out of range reports as a five-pulse red code.
// - Wrong or blocked actuator code reports as a six-pulse red code.
// - Internal fault lights red continuously until a power cycle.
module sstsq_top #(
	parameter int unsigned UNIT_CYCLES = 32'(sstsq_pkg::UNIT_CYC)
) (
	input wire logic clock,
	input wire logic resetn,
	input wire sstsq_pkg::sstsq_sense_t sense,
	input wire sstsq_pkg::sstsq_nv_t nv_in,
	output sstsq_pkg::sstsq_nv_t nv_out,
	output logic nv_write,
	output sstsq_pkg::sstsq_out_t lamps,
	input wire sstsq_pkg::sstsq_bus_t bus,
	output logic [31:0] rdata
);
	import sstsq_pkg::*;

	typedef struct packed {
		sstsq_state_t st;
		logic [2:0] err;
		logic [31:0] unit_cnt;
		logic [2:0] sub;
		logic [3:0] slot;
		logic [WAIT_W-1:0] wait_cnt;
		logic [CODE_W-1:0] cand;
		sstsq_nv_t nv;
		logic nv_wr;
		sstsq_out_t out;
		logic teach_en;
		logic [31:0] rdata;
	} sstsq_regs_t;

	sstsq_regs_t s_r;
	sstsq_regs_t s_nxt;

	// Match of the presented code against every blocked entry.
	logic [BLK_N-1:0] blk_hit;
	genvar gi;
	generate
		for (gi = 0; gi < BLK_N; gi++) begin : g_blk
			assign blk_hit[gi] = s_r.nv.blk_valid[gi] && (s_r.nv.blk_code[gi] == sense.code);
		end
	endgenerate

	// Same check against the image just read at power-up, for the commit.
	logic [BLK_N-1:0] boot_hit;
	generate
		for (gi = 0; gi < BLK_N; gi++) begin : g_boot
			assign boot_hit[gi] = nv_in.blk_valid[gi] && (nv_in.blk_code[gi] == nv_in.pend_code);
		end
	endgenerate

	logic unit_tick;
	assign unit_tick = (s_r.unit_cnt == UNIT_CYCLES - 32'h1);

	// Lamp patterns: a slot is six units; blink is 3 on 3 off, flash 1 on 5 off.
	logic blink;
	logic flash;
	logic code_lamp;
	logic ack_lamp;
	assign blink = (s_r.sub < BLINK_ON_UNITS);
	assign flash = (s_r.sub < FLASH_ON_UNITS);
	assign code_lamp = blink && ({1'b0, s_r.slot} < {2'b00, s_r.err});
	assign ack_lamp = (s_r.wait_cnt < WAIT_W'(ACK_BLINKS) * WAIT_W'(SLOT_UNITS))
		&& ((s_r.wait_cnt % WAIT_W'(SLOT_UNITS)) < WAIT_W'(BLINK_ON_UNITS));

	// Latched error cause, highest priority first.
	logic [2:0] fault_code;
	always_comb begin
		if (sense.fault_internal) begin
			fault_code = ERR_INTERNAL;
		end else if (sense.fault_supply) begin
			fault_code = ERR_SUPPLY;
		end else if (sense.fault_temp) begin
			fault_code = ERR_TEMP;
		end else if (sense.fault_input) begin
			fault_code = ERR_INPUT;
		end else if (sense.fault_feedback) begin
			fault_code = ERR_FEEDBACK;
		end else begin
			fault_code = ERR_NONE;
		end
	end

	logic new_code;
	assign new_code = sense.present && (sense.code != s_r.nv.acc_code);

	// Next-state logic for the whole block.
	always_comb begin
		s_nxt = s_r;
		s_nxt.nv_wr = 1'b0;
		s_nxt.rdata = 32'h0;

		// Lamp time base; the pulse-code slot runs on so codes repeat.
		if (unit_tick) begin
			s_nxt.unit_cnt = 32'h0;
			if (s_r.sub == SLOT_UNITS - 3'h1) begin
				s_nxt.sub = 3'h0;
				if ({1'b0, s_r.slot} >= {2'b00, s_r.err} + {1'b0, GAP_SLOTS} - 5'h1) begin
					s_nxt.slot = 4'h0;
				end else begin
					s_nxt.slot = s_r.slot + 4'h1;
				end
			end else begin
				s_nxt.sub = s_r.sub + 3'h1;
			end
		end else begin
			s_nxt.unit_cnt = s_r.unit_cnt + 32'h1;
		end

		case (s_r.st)
			SST_BOOT: begin
				// Load the stored image; a pending code is committed now unless it is blocked.
				s_nxt.nv = nv_in;
				s_nxt.st = SST_RUN;
				if (nv_in.pend) begin
					s_nxt.nv.pend = 1'b0;
					s_nxt.nv_wr = 1'b1;
					if (boot_hit == '0) begin
						s_nxt.nv.acc_code = nv_in.pend_code;
						s_nxt.nv.learned = 1'b1;
						if (nv_in.learned) begin
							s_nxt.nv.blk_code[nv_in.blk_ptr] = nv_in.acc_code;
							s_nxt.nv.blk_valid[nv_in.blk_ptr] = 1'b1;
							s_nxt.nv.blk_ptr = nv_in.blk_ptr + BLK_PW'(1);
						end
					end
				end
			end
			SST_RUN, SST_LOCK: begin
				if (sense.present && !s_r.nv.learned && blk_hit == '0) begin
					s_nxt.nv.acc_code = sense.code;
					s_nxt.nv.learned = 1'b1;
					s_nxt.nv_wr = 1'b1;
				end else if (new_code && blk_hit != '0) begin
					s_nxt.err = ERR_ACTUATOR;
				end else if (new_code && (!s_r.teach_en || s_r.st == SST_LOCK)) begin
					s_nxt.err = ERR_ACTUATOR;
				end else if (new_code) begin
					s_nxt.cand = sense.code;
					s_nxt.wait_cnt = '0;
					s_nxt.st = SST_WAIT;
				end
			end
			SST_WAIT: begin
				if (!sense.present || sense.code != s_r.cand) begin
					s_nxt.st = SST_LOCK;
				end else if (unit_tick) begin
					if (s_r.wait_cnt == TEACH_WAIT_UNITS - WAIT_W'(1)) begin
						s_nxt.wait_cnt = '0;
						s_nxt.nv.pend = 1'b1;
						s_nxt.nv.pend_code = s_r.cand;
						s_nxt.nv_wr = 1'b1;
						s_nxt.st = SST_LEARN;
					end else begin
						s_nxt.wait_cnt = s_r.wait_cnt + WAIT_W'(1);
					end
				end
			end
			SST_LEARN: begin
				// The pending mark survives only if power drops in time.
				if (!sense.present || sense.code != s_r.cand) begin
					s_nxt.nv.pend = 1'b0;
					s_nxt.nv_wr = 1'b1;
					s_nxt.st = SST_LOCK;
				end else if (unit_tick) begin
					if (s_r.wait_cnt == TEACH_WINDOW_UNITS - WAIT_W'(1)) begin
						s_nxt.nv.pend = 1'b0;
						s_nxt.nv_wr = 1'b1;
						s_nxt.st = SST_LOCK;
					end else begin
						s_nxt.wait_cnt = s_r.wait_cnt + WAIT_W'(1);
					end
				end
			end
			SST_ERROR: begin
				s_nxt.st = SST_ERROR;
			end
			default: begin
				s_nxt.st = SST_ERROR;
				s_nxt.err = ERR_INTERNAL;
			end
		endcase

		// Monitor faults override everything except boot and an error already latched; errors never clear.
		if (s_r.st != SST_BOOT && s_r.st != SST_ERROR && fault_code != ERR_NONE) begin
			s_nxt.err = fault_code;
		end
		if (s_r.st != SST_BOOT && s_nxt.err != ERR_NONE) begin
			if (s_r.st != SST_ERROR) begin
				s_nxt.slot = 4'h0;
				s_nxt.sub = 3'h0;
				s_nxt.unit_cnt = 32'h0;
			end
			// A fault stops the window timer, so it must also drop the pending mark.
			if (s_r.st == SST_LEARN) begin
				s_nxt.nv.pend = 1'b0;
				s_nxt.nv_wr = 1'b1;
			end
			s_nxt.st = SST_ERROR;
		end

		// Lamp and output decode from the current state.
		s_nxt.out = '0;
		case (s_r.st)
			SST_ERROR: begin
				// Outputs stay low in every error.
				s_nxt.out.red = (s_r.err == ERR_INTERNAL) ? 1'b1 : code_lamp;
			end
			SST_WAIT: begin
				s_nxt.out.red = ack_lamp;
			end
			SST_LEARN: begin
				s_nxt.out.yellow = flash;
				s_nxt.out.diag = flash;
			end
			SST_RUN, SST_LOCK: begin
				if (!sense.present || sense.code != s_r.nv.acc_code) begin
					s_nxt.out.yellow = 1'b1;
				end else if (sense.at_border) begin
					s_nxt.out.yellow = blink;
					s_nxt.out.diag = blink;
					s_nxt.out.safe_a = s_r.out.safe_a;
					s_nxt.out.safe_b = s_r.out.safe_b;
				end else if (!sense.safe_in_a || !sense.safe_in_b) begin
					s_nxt.out.green = blink;
					s_nxt.out.diag = 1'b1;
				end else if (sense.start_wait) begin
					s_nxt.out.green = flash;
					s_nxt.out.diag = 1'b1;
				end else begin
					s_nxt.out.green = 1'b1;
					s_nxt.out.diag = 1'b1;
					s_nxt.out.safe_a = 1'b1;
					s_nxt.out.safe_b = 1'b1;
				end
			end
			default: begin
				s_nxt.out = '0;
			end
		endcase

		// Register port: one write or read per cycle, read data next cycle.
		if (bus.wr && bus.addr == OFS_CTRL) begin
			s_nxt.teach_en = bus.wdata[CTRL_TEACH_BIT];
		end
		if (bus.rd) begin
			case (bus.addr)
				OFS_CTRL: begin
					s_nxt.rdata[CTRL_TEACH_BIT] = s_r.teach_en;
				end
				OFS_STATUS: begin
					s_nxt.rdata[2:0] = s_r.st;
					s_nxt.rdata[STAT_ERR_LSB +: 3] = s_r.err;
					s_nxt.rdata[STAT_LEARNED_BIT] = s_r.nv.learned;
					s_nxt.rdata[STAT_PEND_BIT] = s_r.nv.pend;
				end
				OFS_CODE: begin
					s_nxt.rdata[CODE_W-1:0] = s_r.nv.acc_code;
				end
				default: begin
					s_nxt.rdata = 32'h0;
				end
			endcase
		end
	end

	// State register; power-up is the reset.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
			s_r.st <= SST_BOOT;
			s_r.teach_en <= CTRL_TEACH_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign nv_out = s_r.nv;
	assign nv_write = s_r.nv_wr;
	assign lamps = s_r.out;
	assign rdata = s_r.rdata;
endmodule : sstsq_top

// >>> rtl/sstsq_pkg.sv
package sstsq_pkg;
	// Clock and the lamp timing base.
	localparam longint CLK_HZ = 100_000_000;
	localparam longint CYC_PER_MS = CLK_HZ / 1000;
	localparam longint UNIT_MS = 100;
	localparam longint UNIT_CYC = UNIT_MS * CYC_PER_MS;
	// Teach timing, in ms as stated, then in lamp units.
	localparam longint TEACH_WAIT_MS = 10_000;
	localparam longint TEACH_WINDOW_MS = 120_000;
	localparam int WAIT_W = 11;
	localparam logic [WAIT_W-1:0] TEACH_WAIT_UNITS = WAIT_W'(TEACH_WAIT_MS / UNIT_MS);
	localparam logic [WAIT_W-1:0] TEACH_WINDOW_UNITS = WAIT_W'(TEACH_WINDOW_MS / UNIT_MS);
	// Lamp pattern shape, in units: a slot of six, blink 3 on, flash 1 on.
	localparam logic [2:0] SLOT_UNITS = 3'h6;
	localparam logic [2:0] BLINK_ON_UNITS = 3'h3;
	localparam logic [2:0] FLASH_ON_UNITS = 3'h1;
	localparam logic [3:0] GAP_SLOTS = 4'h2;
	localparam logic [3:0] ACK_BLINKS = 4'h6;
	// Red pulse-count codes.
	localparam logic [2:0] ERR_NONE = 3'h0;
	localparam logic [2:0] ERR_INPUT = 3'h2;
	localparam logic [2:0] ERR_FEEDBACK = 3'h3;
	localparam logic [2:0] ERR_SUPPLY = 3'h4;
	localparam logic [2:0] ERR_TEMP = 3'h5;
	localparam logic [2:0] ERR_ACTUATOR = 3'h6;
	localparam logic [2:0] ERR_INTERNAL = 3'h7;
	// Actuator code store.
	localparam int CODE_W = 8;
	localparam int BLK_N = 4;
	localparam int BLK_PW = 2;
	// Register offsets and reset values.
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_CODE = 4'h8;
	localparam logic CTRL_TEACH_RST = 1'h1;
	localparam int CTRL_TEACH_BIT = 0;
	localparam int STAT_ERR_LSB = 4;
	localparam int STAT_LEARNED_BIT = 8;
	localparam int STAT_PEND_BIT = 9;

	typedef enum logic [2:0] {
		SST_BOOT = 3'b000,
		SST_RUN = 3'b001,
		SST_WAIT = 3'b010,
		SST_LEARN = 3'b011,
		SST_LOCK = 3'b100,
		SST_ERROR = 3'b101
	} sstsq_state_t;

	// Image kept in non-volatile storage across power cycles.
	typedef struct packed {
		logic learned;
		logic [CODE_W-1:0] acc_code;
		logic pend;
		logic [CODE_W-1:0] pend_code;
		logic [BLK_N-1:0] blk_valid;
		logic [BLK_N-1:0][CODE_W-1:0] blk_code;
		logic [BLK_PW-1:0] blk_ptr;
	} sstsq_nv_t;

	// Condition of the sensing front end and monitors.
	typedef struct packed {
		logic present;
		logic at_border;
		logic [CODE_W-1:0] code;
		logic safe_in_a;
		logic safe_in_b;
		logic start_wait;
		logic fault_input;
		logic fault_feedback;
		logic fault_supply;
		logic fault_temp;
		logic fault_internal;
	} sstsq_sense_t;

	typedef struct packed {
		logic green;
		logic red;
		logic yellow;
		logic diag;
		logic safe_a;
		logic safe_b;
	} sstsq_out_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} sstsq_bus_t;
endpackage : sstsq_pkg

// >>> bench/sstsq_assertions.sv
`timescale 1ns/100ps
module sstsq_assertions (
	input wire logic clock,
	input wire logic resetn,
	input wire sstsq_pkg::sstsq_sense_t sense,
	input wire sstsq_pkg::sstsq_nv_t nv_in,
	input wire sstsq_pkg::sstsq_nv_t nv_out,
	input wire logic nv_write,
	input wire sstsq_pkg::sstsq_out_t lamps,
	input wire sstsq_pkg::sstsq_bus_t bus,
	input wire logic [31:0] rdata
);
	import sstsq_pkg::*;
	logic any_fault;
	logic [2:0] err_age_r;
	assign any_fault = |{sense.fault_input, sense.fault_feedback, sense.fault_supply,
		sense.fault_temp, sense.fault_internal};
	// Ages a seen fault, so the latch is judged only once the error has settled.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			err_age_r <= 3'h0;
		end else if ((any_fault || err_age_r != 3'h0) && err_age_r != 3'h7) begin
			err_age_r <= err_age_r + 3'h1;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence quiet_s;
		!lamps.green && !lamps.yellow && !lamps.diag && !lamps.safe_a && !lamps.safe_b;
	endsequence
	sequence learn_look_s;
		!lamps.green && !lamps.red && !lamps.safe_a && !lamps.safe_b;
	endsequence
	// The outputs switch as a pair and never while red is shown.
	safe_pair_a: assert property ((lamps.safe_a || lamps.safe_b) |->
		(lamps.safe_a && lamps.safe_b && !lamps.red)) else $error("safety outputs split");
	err_quiet_a: assert property (any_fault |-> ##[1:3] quiet_s [*8])
		else $error("error state not quiet");
	err_hold_a: assert property (err_age_r == 3'h7 |-> quiet_s)
		else $error("error state left");
	internal_steady_a: assert property ($rose(sense.fault_internal) |->
		##[1:4] lamps.red [*8]) else $error("internal fault not steady red");
	learn_show_a: assert property ((nv_write && nv_out.pend) |->
		##[1:3] learn_look_s [*8]) else $error("learning indication wrong");
	pend_safe_a: assert property (nv_out.pend |-> !lamps.safe_a && !lamps.safe_b)
		else $error("outputs on while pending");
	border_a: assert property ((sense.at_border && $past(sense.at_border, 3)
		&& err_age_r == 3'h0) |-> !lamps.green && !lamps.red) else $error("border lamps wrong");
	// The store still holds the image read at power-up when the commit is written back.
	commit_a: assert property ((nv_write && nv_in.pend && nv_in.learned && !nv_out.pend
		&& nv_out.acc_code != nv_in.acc_code) |->
		(nv_out.acc_code == nv_in.pend_code && nv_out.blk_valid[nv_in.blk_ptr]
		&& nv_out.blk_code[nv_in.blk_ptr] == nv_in.acc_code))
		else $error("commit did not block old code");
endmodule : sstsq_assertions

// >>> bench/sstsq_nv_model.sv
`timescale 1ns/100ps
module sstsq_nv_model (
	input wire logic clock,
	input wire logic nv_write,
	input wire sstsq_pkg::sstsq_nv_t nv_out,
	output sstsq_pkg::sstsq_nv_t nv_in
);
	import sstsq_pkg::*;
	sstsq_nv_t store_r = '0;
	assign nv_in = store_r;
	// The store ignores reset, since a power cycle must not lose the image.
	always @(posedge clock) begin
		if (nv_write) begin
			store_r <= nv_out;
		end
	end
endmodule : sstsq_nv_model

// >>> bench/sstsq_test.sv
`timescale 1ns/100ps
module sstsq_test;
	import sstsq_pkg::*;
	localparam int U = 4;
	localparam int SL = 6 * U;
	localparam int GR = 5;
	localparam int RD = 4;
	localparam int YL = 3;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	sstsq_sense_t sense = '0;
	sstsq_bus_t bus = '0;
	sstsq_nv_t nv_in;
	sstsq_nv_t nv_out;
	logic nv_write;
	sstsq_out_t lamps;
	logic [5:0] lv;
	logic [31:0] rdata;
	logic [31:0] d;
	int n_fail = 0;
	int n_checks = 0;
	int t;
	int k;
	int f;
	int codes[5] = '{2, 3, 4, 5, 7};
	assign lv = lamps;
	sstsq_top #(.UNIT_CYCLES(U)) dut_u (.clock, .resetn, .sense, .nv_in, .nv_out, .nv_write,
		.lamps, .bus, .rdata);
	sstsq_nv_model nv_u (.clock, .nv_write, .nv_out, .nv_in);
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clock);
	endtask : step
	// A power cycle, as the operator makes it.
	task automatic pwr;
		@(posedge clock);
		resetn <= 1'b0;
		step(2);
		resetn <= 1'b1;
		step(6);
	endtask : pwr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 v = rdata;
		// Return on an edge so that the stimulus that follows changes there.
		@(posedge clock);
	endtask : rd
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask : wr
	// Counts lit cycles and rising edges of one lamp over a window.
	task automatic meas(input int i, input int n, output int on, output int ed);
		logic p;
		on = 0;
		ed = 0;
		@(posedge clock);
		#1 p = lv[i];
		repeat (n) begin
			@(posedge clock);
			#1;
			on += int'(lv[i]);
			ed += int'(lv[i] && !p);
			p = lv[i];
		end
		@(posedge clock);
	endtask : meas
	task automatic wnv(input int mx, output int c);
		c = 0;
		do begin
			@(posedge clock);
			#1 c++;
		end while (nv_write !== 1'b1 && c <= mx);
		if (nv_write !== 1'b1) begin
			n_fail++;
			end_of_test();
		end
	endtask : wnv
	initial begin
		step(60000);
		n_fail++;
		end_of_test();
	end
	initial begin
		sense.present <= 1'b1;
		sense.code <= 8'h11;
		sense.safe_in_a <= 1'b1;
		sense.safe_in_b <= 1'b1;
		step(2);
		resetn <= 1'b1;
		step(8);
		chk("lamps run", 32'(lv), 32'h27);
		rd(OFS_STATUS, d);
		chk("learned", 32'(d[STAT_LEARNED_BIT]), 32'h1);
		rd(OFS_CODE, d);
		chk("first code", 32'(d[7:0]), 32'h11);
		rd(OFS_CTRL, d);
		chk("ctrl reset", d, 32'h1);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_CTRL, d);
		chk("ctrl write", d, 32'h0);
		wr(OFS_CTRL, 32'h1);
		rd(4'hC, d);
		chk("unmapped", d, 32'h0);
		sense.safe_in_a <= 1'b0;
		sense.safe_in_b <= 1'b0;
		step(4);
		meas(GR, 4 * SL, t, k);
		chk("green blink", t, 2 * SL);
		chk("blink outs", 32'(lv[2:0]), 32'h4);
		sense.safe_in_a <= 1'b1;
		sense.safe_in_b <= 1'b1;
		sense.start_wait <= 1'b1;
		step(4);
		meas(GR, 4 * SL, t, k);
		chk("green flash", t, 4 * U);
		chk("flash outs", 32'(lv[2:0]), 32'h4);
		sense.start_wait <= 1'b0;
		step(4);
		sense.at_border <= 1'b1;
		step(4);
		meas(YL, 4 * SL, t, k);
		chk("yellow blink", t, 2 * SL);
		chk("border outs", 32'(lv[1:0]), 32'h3);
		sense.at_border <= 1'b0;
		step(4);
		sense.code <= 8'h22;
		meas(RD, 95 * U, t, k);
		chk("ack blinks", k, 6);
		wnv(20 * U, t);
		chk("pend set", 32'(nv_out.pend), 32'h1);
		chk("wait time", 32'(t + 95 * U >= 100 * U - 4 && t + 95 * U <= 100 * U + 4), 1);
		meas(YL, 4 * SL, t, k);
		chk("learn flash", t, 4 * U);
		pwr();
		rd(OFS_CODE, d);
		chk("commit", 32'(d[7:0]), 32'h22);
		chk("blocked", 32'({nv_out.blk_valid[0], nv_out.blk_code[0]}), 32'h111);
		chk("lamps new", 32'(lv), 32'h27);
		sense.code <= 8'h11;
		step(6);
		meas(RD, 8 * SL, t, k);
		chk("blocked code", k, 6);
		sense.code <= 8'h22;
		step(6);
		meas(RD, 8 * SL, t, k);
		chk("latched", k, 6);
		pwr();
		sense.code <= 8'h33;
		step(200);
		sense.present <= 1'b0;
		step(6);
		rd(OFS_STATUS, d);
		chk("cancelled", 32'(d[2:0]), 32'h4);
		sense.present <= 1'b1;
		pwr();
		wnv(110 * U, t);
		step(1200 * U + 40);
		chk("window over", 32'(nv_out.pend), 32'h0);
		pwr();
		rd(OFS_CODE, d);
		chk("not learned", 32'(d[7:0]), 32'h22);
		sense.code <= 8'h22;
		for (f = 0; f < 5; f++) begin
			pwr();
			sense[4 - f] <= 1'b1;
			@(posedge clock);
			sense[4 - f] <= 1'b0;
			step(6);
			meas(RD, (codes[f] + 2) * SL, t, k);
			chk("fault code", f == 4 ? t : k, f == 4 ? 9 * SL : codes[f]);
		end
		end_of_test();
	end
endmodule : sstsq_test
bind sstsq_top sstsq_assertions chk_u (.clock, .resetn, .sense, .nv_in, .nv_out, .nv_write,
	.lamps, .bus, .rdata);
